// ---- core/cclk_pkg.sv ----
// Purpose: constants and types shared by the card clock control block
// Assumes: 10 MHz core clock, 32-bit APB register access
// Notes: register byte offsets are local choices
package cclk_pkg;
    localparam logic [11:0] CCLK_CCR_ADDR = 12'h0000;
    localparam logic [11:0] CCLK_STAT_ADDR = 12'h0004;
    localparam logic [11:0] CCLK_CFG_ADDR = 12'h0008;
    // card clock control bit positions
    localparam int CCLK_ICE_BIT = 0;
    localparam int CCLK_ICS_BIT = 1;
    localparam int CCLK_CCE_BIT = 2;
    localparam int CCLK_GSEL_BIT = 5;
    localparam int CCLK_DIVH_LSB = 6;
    localparam int CCLK_DIVL_LSB = 8;
    // config register bit positions
    localparam int CCLK_PVE_BIT = 0;
    localparam int CCLK_PGSEL_BIT = 1;
    localparam int CCLK_PDIV_LSB = 2;
    localparam logic [15:0] CCLK_CCR_RESET = 16'h0000;
    // oscillator settle time in ns and in core cycles (rounded up)
    localparam int CCLK_SETTLE_NS = 1000;
    localparam int CCLK_CLK_PERIOD_NS = 100;
    localparam int CCLK_SETTLE_CYC = (CCLK_SETTLE_NS + CCLK_CLK_PERIOD_NS - 1) / CCLK_CLK_PERIOD_NS;
    localparam int CCLK_DIV_W = 10;
    typedef enum logic [1:0] {CCLK_OFF, CCLK_SETTLE, CCLK_STABLE} cclk_osc_e;
endpackage

// ---- core/cclk_gen_if.sv ----
// Purpose: control bundle between clock control and the card clock generator
// Assumes: one core clock domain
// Notes: settings are only sampled while the clock is parked low
`timescale 1ns/1ps
interface cclk_gen_if;
    logic run;
    logic gen_sel;
    logic [9:0] divider;
    logic stopped;
    modport ctrl (output run, output gen_sel, output divider, input stopped);
    modport gen (input run, input gen_sel, input divider, output stopped);
endinterface

// ---- core/cclk_gen.sv ----
// Purpose: card bus clock generator, divided or multiplied source
// Assumes: base and multiplied clocks arrive as one-cycle enable pulses
// Notes: settings latch only while parked low, so no short pulse escapes
`timescale 1ns/1ps
module cclk_gen
    import cclk_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic base_tick_in,
    input wire logic mult_tick_in,
    cclk_gen_if.gen ctl,
    output logic card_bus_clock_out
);
    logic clk_reg, clk_next;
    logic [9:0] cnt_reg, cnt_next;
    logic [9:0] div_reg, div_next;
    logic sel_reg, sel_next;
    logic tick;

    // the selected source paces every toggle
    assign tick = sel_reg ? mult_tick_in : base_tick_in;
    assign ctl.stopped = !clk_reg && !ctl.run;

    // toggle after n ticks (period 2n), zero passes the source straight
    always_comb begin
        clk_next = clk_reg;
        cnt_next = cnt_reg;
        div_next = div_reg;
        sel_next = sel_reg;
        if (!clk_reg && !ctl.run) begin
            div_next = ctl.divider;
            sel_next = ctl.gen_sel;
            cnt_next = 10'h0000;
        end else if (div_reg == 10'h0000) begin
            clk_next = ctl.run && tick;
        end else if (tick) begin
            if (cnt_reg + 10'h0001 >= div_reg) begin
                cnt_next = 10'h0000;
                // stop only on the falling half, leaving the line low
                clk_next = !clk_reg;
            end else begin
                cnt_next = cnt_reg + 10'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            clk_reg <= 1'b0;
            cnt_reg <= 10'h0000;
            div_reg <= 10'h0000;
            sel_reg <= 1'b0;
        end else begin
            clk_reg <= clk_next;
            cnt_reg <= cnt_next;
            div_reg <= div_next;
            sel_reg <= sel_next;
        end
    end

    assign card_bus_clock_out = clk_reg;
endmodule

// ---- core/cclk_ctrl.sv ----
// Purpose: card host clock control with APB registers
// Assumes: card detect pin is asynchronous; base/mult ticks are core-domain
// Notes: zero-wait APB slave, unmapped addresses read zero and set pslverr
//   card removal clears the card clock enable and wins over a same-cycle set
//   preset mode takes select and divider from the single config register
// How it works
// - internal clock enable low stops the internal clock (gated enable).
// - registers stay readable and writable while the internal clock is off.
// - enable starts oscillation; stable flag rises after settle time only.
// - card detect sampling runs always, independent of internal clock enable.
// - card clock enable 0 stops the card clock, 1 runs it once the internal clock is stable.
// - card clock keeps its frequency and stops with the line low.
// - card removal clears card clock enable automatically.
// - without multiplier capability the generator select ignores writes, reads 0.
// - with preset enable the generator select loads from the preset value.
// - select 0 uses divided base clock, select 1 uses multiplied clock.
// - two upper divider bits are bits 9..8 of the 10-bit divider.
`timescale 1ns/1ps
module cclk_ctrl
    import cclk_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_detect_in,
    input wire logic clock_multiplier_capability_in,
    input wire logic base_clock_tick_in,
    input wire logic multiplied_clock_tick_in,
    output logic internal_clock_gate_out,
    output logic card_present_flag_out,
    output logic card_bus_clock_out
);
    cclk_gen_if gif ();

    // control register fields
    logic ice_reg;
    logic ice_next;
    logic cce_reg;
    logic cce_next;
    logic gsel_reg;
    logic gsel_next;
    logic [9:0] div_reg;
    logic [9:0] div_next;
    // preset fields of the config register
    logic pve_reg;
    logic pve_next;
    logic pgsel_reg;
    logic pgsel_next;
    logic [9:0] pdiv_reg;
    logic [9:0] pdiv_next;
    // oscillator sequencing
    cclk_osc_e osc_reg;
    cclk_osc_e osc_next;
    logic [7:0] settle_reg;
    logic [7:0] settle_next;
    logic osc_stable;
    // read data holding register
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    // card detect synchroniser and its edge memory
    logic cd_meta_reg;
    logic cd_meta_next;
    logic cd_sync_reg;
    logic cd_sync_next;
    logic cd_prev_reg;
    logic cd_prev_next;
    logic card_removed;
    // bus decode
    logic hit_ccr;
    logic hit_stat;
    logic hit_cfg;
    logic hit_any;
    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic rd_en;
    // write fields
    logic wr_ice;
    logic wr_cce;
    logic wr_gsel;
    logic [9:0] wr_div;
    logic wr_pve;
    logic wr_pgsel;
    logic [9:0] wr_pdiv;
    // effective generator settings and read views
    logic eff_gsel;
    logic [9:0] eff_div;
    logic [15:0] ccr_view;
    logic [31:0] stat_view;
    logic [31:0] cfg_view;

    // detect pin crosses two flops, clocked whatever the internal enable says
    always_comb begin
        cd_meta_next = card_detect_in;
        cd_sync_next = cd_meta_reg;
        cd_prev_next = cd_sync_reg;
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cd_meta_reg <= 1'b0;
            cd_sync_reg <= 1'b0;
            cd_prev_reg <= 1'b0;
        end else begin
            cd_meta_reg <= cd_meta_next;
            cd_sync_reg <= cd_sync_next;
            cd_prev_reg <= cd_prev_next;
        end
    end

    // a falling synchronised level means the card has left the slot
    assign card_removed = cd_prev_reg && !cd_sync_reg;

    // address decode; the register path never looks at the internal enable
    always_comb begin
        hit_ccr = 1'b0;
        hit_stat = 1'b0;
        hit_cfg = 1'b0;
        if (paddr == CCLK_CCR_ADDR) begin
            hit_ccr = 1'b1;
        end else if (paddr == CCLK_STAT_ADDR) begin
            hit_stat = 1'b1;
        end else if (paddr == CCLK_CFG_ADDR) begin
            hit_cfg = 1'b1;
        end
    end

    // zero-wait slave: every access completes in its first access cycle
    assign hit_any = hit_ccr || hit_stat || hit_cfg;
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_en = access_phase && pwrite;
    assign rd_en = setup_phase && !pwrite;
    assign pready = 1'b1;
    assign pslverr = access_phase && !hit_any;

    // write fields lifted out of the bus word at their fixed positions
    assign wr_ice = pwdata[CCLK_ICE_BIT];
    assign wr_cce = pwdata[CCLK_CCE_BIT];
    assign wr_gsel = pwdata[CCLK_GSEL_BIT];
    assign wr_div = {pwdata[CCLK_DIVH_LSB +: 2], pwdata[CCLK_DIVL_LSB +: 8]};
    assign wr_pve = pwdata[CCLK_PVE_BIT];
    assign wr_pgsel = pwdata[CCLK_PGSEL_BIT];
    assign wr_pdiv = pwdata[CCLK_PDIV_LSB +: 10];

    // preset mode overrides the software select and divider
    assign eff_gsel = clock_multiplier_capability_in
        && (pve_reg ? pgsel_reg : gsel_reg);
    assign eff_div = pve_reg ? pdiv_reg : div_reg;
    assign osc_stable = (osc_reg == CCLK_STABLE);

    // control view placed by field position, reserved bits stay zero
    always_comb begin
        ccr_view = 16'h0000;
        ccr_view[CCLK_ICE_BIT] = ice_reg;
        ccr_view[CCLK_ICS_BIT] = osc_stable;
        ccr_view[CCLK_CCE_BIT] = cce_reg;
        ccr_view[CCLK_GSEL_BIT] = eff_gsel;
        ccr_view[CCLK_DIVH_LSB +: 2] = div_reg[9:8];
        ccr_view[CCLK_DIVL_LSB +: 8] = div_reg[7:0];
    end

    // status view: clock parked, card present
    assign stat_view = {30'h0000_0000, gif.stopped, cd_sync_reg};

    // config view placed by field position
    always_comb begin
        cfg_view = 32'h0000_0000;
        cfg_view[CCLK_PVE_BIT] = pve_reg;
        cfg_view[CCLK_PGSEL_BIT] = pgsel_reg;
        cfg_view[CCLK_PDIV_LSB +: 10] = pdiv_reg;
    end

    // software writes, with card removal clearing the card clock enable
    always_comb begin
        ice_next = ice_reg;
        cce_next = cce_reg;
        gsel_next = gsel_reg;
        div_next = div_reg;
        pve_next = pve_reg;
        pgsel_next = pgsel_reg;
        pdiv_next = pdiv_reg;
        if (wr_en && hit_ccr) begin
            ice_next = wr_ice;
            cce_next = wr_cce;
            // without the multiplier the select bit ignores writes
            if (clock_multiplier_capability_in) begin
                gsel_next = wr_gsel;
            end
            div_next = wr_div;
        end else if (wr_en && hit_cfg) begin
            pve_next = wr_pve;
            pgsel_next = wr_pgsel;
            pdiv_next = wr_pdiv;
        end
        // removal wins over a simultaneous software set
        if (card_removed) begin
            cce_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ice_reg <= CCLK_CCR_RESET[CCLK_ICE_BIT];
            cce_reg <= CCLK_CCR_RESET[CCLK_CCE_BIT];
            gsel_reg <= CCLK_CCR_RESET[CCLK_GSEL_BIT];
            div_reg <= {CCLK_CCR_RESET[CCLK_DIVH_LSB +: 2], CCLK_CCR_RESET[CCLK_DIVL_LSB +: 8]};
            pve_reg <= 1'b0;
            pgsel_reg <= 1'b0;
            pdiv_reg <= 10'h000;
        end else begin
            ice_reg <= ice_next;
            cce_reg <= cce_next;
            gsel_reg <= gsel_next;
            div_reg <= div_next;
            pve_reg <= pve_next;
            pgsel_reg <= pgsel_next;
            pdiv_reg <= pdiv_next;
        end
    end

    // stable flag rises only after the settle count, drops at once on disable
    always_comb begin
        osc_next = osc_reg;
        settle_next = settle_reg;
        case (osc_reg)
            CCLK_OFF: begin
                settle_next = 8'h00;
                if (ice_reg) begin
                    osc_next = CCLK_SETTLE;
                end
            end
            CCLK_SETTLE: begin
                settle_next = settle_reg + 8'h01;
                if (!ice_reg) begin
                    osc_next = CCLK_OFF;
                end else if (settle_reg >= 8'(CCLK_SETTLE_CYC - 1)) begin
                    osc_next = CCLK_STABLE;
                end
            end
            default: begin
                if (!ice_reg) begin
                    osc_next = CCLK_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            osc_reg <= CCLK_OFF;
            settle_reg <= 8'h00;
        end else begin
            osc_reg <= osc_next;
            settle_reg <= settle_next;
        end
    end

    // read data captured in the setup cycle, held until the next read
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_en) begin
            if (hit_ccr) begin
                rdata_next = {16'h0000, ccr_view};
            end else if (hit_stat) begin
                rdata_next = stat_view;
            end else if (hit_cfg) begin
                rdata_next = cfg_view;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // the card clock may only run with a stable internal clock
    assign gif.run = cce_reg && osc_stable;
    assign gif.gen_sel = eff_gsel;
    assign gif.divider = eff_div;

    cclk_gen u_gen (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .base_tick_in(base_clock_tick_in),
        .mult_tick_in(multiplied_clock_tick_in),
        .ctl(gif),
        .card_bus_clock_out(card_bus_clock_out)
    );

    // outputs come straight from flops
    assign prdata = rdata_reg;
    assign internal_clock_gate_out = ice_reg;
    assign card_present_flag_out = cd_sync_reg;
endmodule

// ---- bench/cclk_ctrl_asserts.sv ----
// Purpose: port checks for the card clock control block
// Assumes: one core clock, sync active-high reset
// Notes: ticks are one-cycle enables of the source clocks
`timescale 1ns/1ps
module cclk_ctrl_asserts
    import cclk_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic card_detect_in,
    input wire logic base_clock_tick_in,
    input wire logic multiplied_clock_tick_in,
    input wire logic internal_clock_gate_out,
    input wire logic card_present_flag_out,
    input wire logic card_bus_clock_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // control register write in its access phase
    sequence s_ccr_wr;
        psel && penable && pwrite && paddr == CCLK_CCR_ADDR;
    endsequence
    // card gone long enough for the auto clear to land
    sequence s_absent;
        !card_present_flag_out [*6];
    endsequence
    chk_gate_on: assert property (s_ccr_wr ##0 pwdata[0] |-> ##[1:2] internal_clock_gate_out)
        else $error("gate did not open");
    chk_gate_off: assert property (s_ccr_wr ##0 !pwdata[0] |-> ##[1:2] !internal_clock_gate_out)
        else $error("gate did not close");
    chk_rd_gated: assert property (psel && !penable && !pwrite && paddr == CCLK_CCR_ADDR
        && !internal_clock_gate_out |=> !prdata[0]) else $error("bad read while gated");
    chk_ready_high: assert property (psel |-> pready)
        else $error("access stalled");
    chk_bad_addr: assert property (psel && penable && paddr > CCLK_CFG_ADDR |-> pslverr)
        else $error("unmapped access not flagged");
    chk_detect_sync: assert property (card_detect_in != $past(card_detect_in)
        |-> ##[1:3] card_present_flag_out == card_detect_in) else $error("detect lost");
    chk_absent_norise: assert property (s_absent |-> !$rose(card_bus_clock_out))
        else $error("clock rose with card gone");
    chk_idle_stable: assert property ((!base_clock_tick_in && !multiplied_clock_tick_in) [*4]
        |=> $stable(card_bus_clock_out)) else $error("clock moved without source tick");
endmodule

bind cclk_ctrl cclk_ctrl_asserts i_chk (.*);

// ---- bench/cclk_card_model.sv ----
// Purpose: card side stand-in: detect pin and clock edge count
// Assumes: detect pin high while a card sits in the slot
// Notes: no contact bounce is modelled
`timescale 1ns/1ps
module cclk_card_model (
    input wire logic card_clk_in,
    input wire logic inserted_in,
    output logic card_detect_out,
    output int edges_out
);
    int rises = 0;
    // slot state drives the pin even with the host clock gated
    assign card_detect_out = inserted_in;
    assign edges_out = rises;
    // the card acts on rising edges only
    always @(posedge card_clk_in) begin
        rises <= rises + 1;
    end
endmodule

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the card clock control block
// Assumes: APB master here, source ticks from a local counter
// Notes: clock rates are judged by counting card clock rises
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    import cclk_pkg::*;
    logic core_clk_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, err_q, cap = 0, ins = 1, ton = 1, base = 0, mult = 0;
    logic gate, flag, cclk, det;
    logic [1:0] cnt = '0;
    int err_total = 0, comparisons = 0, edges;
    cclk_ctrl i_dut (.card_detect_in(det), .clock_multiplier_capability_in(cap),
        .base_clock_tick_in(base), .multiplied_clock_tick_in(mult),
        .internal_clock_gate_out(gate), .card_present_flag_out(flag),
        .card_bus_clock_out(cclk), .*);
    cclk_card_model i_card (.card_clk_in(cclk), .inserted_in(ins), .card_detect_out(det),
        .edges_out(edges));
    initial forever #50 core_clk_in = ~core_clk_in;
    // base tick every 4 cycles, multiplied every 2; ton lets them fall silent
    always @(posedge core_clk_in) begin
        cnt <= cnt + 2'd1;
        base <= ton && cnt == 2'd3;
        mult <= ton && cnt[0];
    end
    // one transfer; waits on pready, giving up after 20 cycles
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err_q = pslverr;
        if (n >= 20) begin
            err_total++;
            finish_test();
        end
        psel <= 0;
        penable <= 0;
    endtask
    task t_osc;
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[15:0], CCLK_CCR_RESET)
        apb(1, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(gate, 1'b0)
        `CHK(flag, 1'b1)
        apb(1, CCLK_CCR_ADDR, 32'h0000_0001);
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[1:0], 2'b01)
        repeat (CCLK_SETTLE_CYC + 4) @(posedge core_clk_in);
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[1:0], 2'b11)
        `CHK(gate, 1'b1)
    endtask
    task t_sel;
        cap <= 0;
        apb(1, CCLK_CCR_ADDR, 32'h0000_0021);
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[5], 1'b0)
        cap <= 1;
        apb(1, CCLK_CCR_ADDR, 32'h0000_0021);
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[5], 1'b1)
        apb(1, CCLK_CFG_ADDR, 32'h0000_0001);
        apb(0, CCLK_CFG_ADDR, 32'h0000_0000);
        `CHK(q[11:0], 12'h001)
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[5], 1'b0)
        apb(1, CCLK_CFG_ADDR, 32'h0000_0000);
    endtask
    // divider set with the card clock off, then run, count rises, stop
    task t_run(input logic [31:0] v, input int lo, input int hi);
        int e;
        apb(1, CCLK_CCR_ADDR, v);
        apb(1, CCLK_CCR_ADDR, v | 32'h0000_0004);
        e = edges;
        repeat (80) @(posedge core_clk_in);
        `CHK(((edges - e) inside {[lo:hi]}), 1'b1)
        apb(1, CCLK_CCR_ADDR, v);
        repeat (20) @(posedge core_clk_in);
        `CHK(cclk, 1'b0)
        e = edges;
        repeat (40) @(posedge core_clk_in);
        `CHK(edges, e)
    endtask
    task t_remove;
        apb(1, CCLK_CCR_ADDR, 32'h0000_0105);
        ton <= 0;
        repeat (10) @(posedge core_clk_in);
        ton <= 1;
        ins <= 0;
        repeat (30) @(posedge core_clk_in);
        `CHK(flag, 1'b0)
        apb(0, CCLK_CCR_ADDR, 32'h0000_0000);
        `CHK(q[2], 1'b0)
        `CHK(cclk, 1'b0)
        apb(0, CCLK_STAT_ADDR, 32'h0000_0000);
        `CHK(q[1:0], 2'b10)
        ins <= 1;
    endtask
    task finish_test;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk_in);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge core_clk_in);
        reset_in <= 0;
        t_osc();
        t_sel();
        t_run(32'h0000_0001, 19, 21);
        t_run(32'h0000_0101, 9, 11);
        t_run(32'h0000_0041, 0, 1);
        t_run(32'h0000_0021, 35, 41);
        t_remove();
        apb(0, 12'h010, 32'h0000_0000);
        `CHK(err_q, 1'b1)
        finish_test();
    end
endmodule
